// ===== usbec_regs.sv
// usbec_regs: usb function control registers, event flags, pad routing
// assumes engine events and tokens are on clk_sys; pads are asynchronous
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module usbec_regs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [usbec_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [usbec_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [usbec_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [usbec_pkg::DATA_W-1:0] ev_a,
    input wire logic [usbec_pkg::DATA_W-1:0] ev_b,
    input wire logic ep4_rx_data1,
    input wire logic ep4_rx_error,
    input wire logic [usbec_pkg::BULK_CNT_W-1:0] ep4_rx_bytes,
    input wire logic tok_valid,
    input wire usbec_pkg::usbec_tok_t tok_kind,
    input wire logic [usbec_pkg::FUNC_ADDR_W-1:0] tok_addr,
    input wire logic [usbec_pkg::EP_W-1:0] tok_ep,
    output logic rsp_valid,
    output usbec_pkg::usbec_rsp_t rsp_code,
    output logic rsp_data1,
    output logic [usbec_pkg::BULK_CNT_W-1:0] rsp_count,
    output logic bus_pin_enable,
    output logic [usbec_pkg::FUNC_ADDR_W-1:0] device_bus_address,
    output logic suspend_req,
    output logic resume_drive,
    output logic pullup_en,
    input wire logic [1:0] pad_i,
    output logic [1:0] pad_o,
    output logic [1:0] pad_oe,
    input wire logic [1:0] xcvr_o,
    input wire logic [1:0] xcvr_oe,
    output logic [1:0] xcvr_i,
    input wire logic [1:0] gpio_o,
    input wire logic [1:0] gpio_oe,
    output logic [1:0] gpio_i
);
    import usbec_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : hit

    usbec_ep_if ep_bus ();
    logic [DATA_W-1:0] pin_addr_reg, flags_a_reg, flags_b_reg, link_ctrl_reg;
    logic [DATA_W-1:0] ep4_ctrl_reg, rdata_reg, rd_mux, keep_a, keep_b;
    logic [DATA_W-1:0] in_reg [NUM_IN];
    logic [BULK_CNT_W-1:0] ep3_count_reg, ep4_count_reg;
    logic ep3_cfg_reg, ep4_tgl_reg, ep4_err_reg, link_susp_reg;
    logic resume_drive_reg, w_pin, w_ctl, w_ep4, w_c3, suspended;
    logic [1:0] pad_meta_reg, pad_sync_reg, pad_o_reg, pad_oe_reg;
    logic [NUM_IN-1:0] in_done;
    assign w_pin = reg_wr && hit(reg_addr, OFS_PIN_ADDR);
    assign w_ctl = reg_wr && hit(reg_addr, OFS_LINK_CTRL);
    assign w_ep4 = reg_wr && hit(reg_addr, OFS_EP4_OUT);
    assign w_c3 = reg_wr && hit(reg_addr, OFS_EP3_COUNT);
    // a 1 written leaves the flag alone, a 0 clears it
    assign keep_a = reg_wr && hit(reg_addr, OFS_FLAGS_A) ?
        reg_wdata : ALL_ONES;
    assign keep_b = reg_wr && hit(reg_addr, OFS_FLAGS_B) ?
        reg_wdata : ALL_ONES;
    assign in_done = {ev_a[F_EP3_TX], ev_a[F_EP2_TX], ev_a[F_EP1_TX],
        ev_a[F_EP0_TX]};

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_addr_reg <= RST_VALUE;
        end else if (w_pin) begin
            pin_addr_reg <= reg_wdata;
        end
    end

    // events win over a clearing write in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flags_a_reg <= RST_VALUE;
            flags_b_reg <= RST_VALUE;
        end else begin
            flags_a_reg <= ev_a | (flags_a_reg & keep_a);
            flags_b_reg <= (ev_b | (flags_b_reg & keep_b))
                & FLAGS_B_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            link_ctrl_reg <= RST_VALUE;
        end else begin
            if (w_ctl) begin
                link_ctrl_reg[B_SUSPEND] <= reg_wdata[B_SUSPEND];
                link_ctrl_reg[B_RESUME] <= reg_wdata[B_RESUME];
                link_ctrl_reg[B_PULLUP] <= reg_wdata[B_PULLUP];
                link_ctrl_reg[B_EP0_RXRDY] <= reg_wdata[B_EP0_RXRDY];
            end else if (ev_a[F_EP0_RX]) begin
                link_ctrl_reg[B_EP0_RXRDY] <= 1'b0;
            end
            // configure bits are write-1-set, dropped by bus reset
            if (w_ctl && reg_wdata[B_EP1_CFG]) begin
                link_ctrl_reg[B_EP1_CFG] <= 1'b1;
            end else if (ev_b[F_BRST]) begin
                link_ctrl_reg[B_EP1_CFG] <= 1'b0;
            end
            if (w_ctl && reg_wdata[B_EP2_CFG]) begin
                link_ctrl_reg[B_EP2_CFG] <= 1'b1;
            end else if (ev_b[F_BRST]) begin
                link_ctrl_reg[B_EP2_CFG] <= 1'b0;
            end
        end
    end
    generate
        for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_in
            logic [DATA_W-1:0] ctl_reg;
            logic wr_hit;
            assign wr_hit = reg_wr && hit(reg_addr, IN_OFS[gi]);
            assign in_reg[gi] = ctl_reg;
            // a firmware write in the done cycle re-arms the endpoint
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    ctl_reg <= RST_VALUE;
                end else if (wr_hit) begin
                    ctl_reg <= reg_wdata & IN_WR_MASK[gi];
                end else if (in_done[gi]) begin
                    ctl_reg[B_READY] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ep3_cfg_reg <= 1'b0;
        end else if (reg_wr && hit(reg_addr, OFS_EP3_IN)
            && reg_wdata[B_EP3_CFG]) begin
            ep3_cfg_reg <= 1'b1;
        end else if (ev_b[F_BRST]) begin
            ep3_cfg_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ep3_count_reg <= '0;
        end else if (w_c3) begin
            ep3_count_reg <= reg_wdata[BULK_CNT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ep4_ctrl_reg <= RST_VALUE;
        end else begin
            if (w_ep4) begin
                ep4_ctrl_reg[B_READY] <= reg_wdata[B_READY];
                ep4_ctrl_reg[B_EP4_STALL] <= reg_wdata[B_EP4_STALL];
            end else if (ev_a[F_EP4_RX]) begin
                ep4_ctrl_reg[B_READY] <= 1'b0;
            end
            if (w_ep4 && reg_wdata[B_EP4_CFG]) begin
                ep4_ctrl_reg[B_EP4_CFG] <= 1'b1;
            end else if (ev_b[F_BRST]) begin
                ep4_ctrl_reg[B_EP4_CFG] <= 1'b0;
            end
        end
    end

    // receive status is captured with the ep4 receive event
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ep4_tgl_reg <= 1'b0;
            ep4_err_reg <= 1'b0;
            ep4_count_reg <= '0;
        end else if (ev_a[F_EP4_RX]) begin
            ep4_tgl_reg <= ep4_rx_data1;
            ep4_err_reg <= ep4_rx_error;
            ep4_count_reg <= ep4_rx_bytes;
        end
    end

    // bus suspend holds until the host resumes or resets the bus
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            link_susp_reg <= 1'b0;
        end else if (ev_a[F_SUSP]) begin
            link_susp_reg <= 1'b1;
        end else if (ev_b[F_RSM] || ev_b[F_BRST]) begin
            link_susp_reg <= 1'b0;
        end
    end
    assign suspended = link_susp_reg || link_ctrl_reg[B_SUSPEND];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resume_drive_reg <= 1'b0;
        end else begin
            resume_drive_reg <= link_ctrl_reg[B_RESUME] && suspended;
        end
    end

    // pads are asynchronous: two flops before anything reads them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pad_meta_reg <= 2'h0;
            pad_sync_reg <= 2'h0;
        end else begin
            pad_meta_reg <= pad_i;
            pad_sync_reg <= pad_meta_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pad_o_reg <= 2'h0;
            pad_oe_reg <= 2'h0;
        end else if (bus_pin_enable) begin
            pad_o_reg <= xcvr_o;
            pad_oe_reg <= xcvr_oe;
        end else begin
            pad_o_reg <= gpio_o;
            pad_oe_reg <= gpio_oe;
        end
    end

    assign xcvr_i = bus_pin_enable ? pad_sync_reg : 2'h0;
    assign gpio_i = bus_pin_enable ? 2'h0 : pad_sync_reg;
    assign pad_o = pad_o_reg;
    assign pad_oe = pad_oe_reg;

    always_comb begin
        rd_mux = RST_VALUE;
        case (reg_addr)
            OFS_PIN_ADDR: rd_mux = pin_addr_reg;
            OFS_FLAGS_A: rd_mux = flags_a_reg;
            OFS_FLAGS_B: rd_mux = flags_b_reg;
            OFS_LINK_CTRL: rd_mux = link_ctrl_reg & LINK_CTRL_MASK;
            OFS_EP0_IN: rd_mux = in_reg[0];
            OFS_EP1_IN: rd_mux = in_reg[1];
            OFS_EP2_IN: rd_mux = in_reg[2];
            OFS_EP3_IN: begin
                rd_mux = in_reg[3];
                rd_mux[B_EP3_CFG] = ep3_cfg_reg;
            end
            OFS_EP4_OUT: begin
                rd_mux = ep4_ctrl_reg & EP4_CTRL_MASK;
                rd_mux[B_EP4_CFG] = ep4_ctrl_reg[B_EP4_CFG];
                rd_mux[B_EP4_TGL] = ep4_tgl_reg;
                rd_mux[B_EP4_ERR] = ep4_err_reg;
            end
            OFS_EP3_COUNT: rd_mux = {1'b0, ep3_count_reg};
            OFS_EP4_COUNT: rd_mux = {1'b0, ep4_count_reg};
            default: rd_mux = RST_VALUE;
        endcase
    end

    // read data lives for exactly the one cycle after the strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= RST_VALUE;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : RST_VALUE;
        end
    end

    assign reg_rdata = rdata_reg;
    assign bus_pin_enable = pin_addr_reg[B_PIN_EN];
    assign device_bus_address = pin_addr_reg[FUNC_ADDR_W-1:0];
    assign suspend_req = link_ctrl_reg[B_SUSPEND];
    assign resume_drive = resume_drive_reg;
    assign pullup_en = link_ctrl_reg[B_PULLUP];

    assign ep_bus.dev_addr = pin_addr_reg[FUNC_ADDR_W-1:0];
    assign ep_bus.ready = {ep4_ctrl_reg[B_READY], in_reg[3][B_READY],
        in_reg[2][B_READY], in_reg[1][B_READY], in_reg[0][B_READY]};
    assign ep_bus.stall = {ep4_ctrl_reg[B_EP4_STALL], in_reg[3][B_STALL],
        in_reg[2][B_STALL], in_reg[1][B_STALL], in_reg[0][B_STALL]};
    assign ep_bus.configured = {ep4_ctrl_reg[B_EP4_CFG], ep3_cfg_reg,
        link_ctrl_reg[B_EP2_CFG], link_ctrl_reg[B_EP1_CFG], 1'b1};
    assign ep_bus.tx_toggle = {1'b0, in_reg[3][B_TOGGLE],
        in_reg[2][B_TOGGLE], in_reg[1][B_TOGGLE], in_reg[0][B_TOGGLE]};
    assign ep_bus.tx_count[0] = BULK_CNT_W'(in_reg[0][CNT_W-1:0]);
    assign ep_bus.tx_count[1] = BULK_CNT_W'(in_reg[1][CNT_W-1:0]);
    assign ep_bus.tx_count[2] = BULK_CNT_W'(in_reg[2][CNT_W-1:0]);
    assign ep_bus.tx_count[3] = ep3_count_reg;
    assign ep_bus.tx_count[4] = '0;
    assign ep_bus.ep0_rx_ready = link_ctrl_reg[B_EP0_RXRDY];
    assign ep_bus.ep0_stall_in = in_reg[0][B_STALL_IN0];

    usbec_hs_decide u_decide (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ep(ep_bus.decide),
        .tok_valid(tok_valid),
        .tok_kind(tok_kind),
        .tok_addr(tok_addr),
        .tok_ep(tok_ep),
        .rsp_valid(rsp_valid),
        .rsp_code(rsp_code),
        .rsp_data1(rsp_data1),
        .rsp_count(rsp_count)
    );

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_flag_set_wins: assert property (
        ev_a != RST_VALUE |=> (flags_a_reg & $past(ev_a)) == $past(ev_a))
        else $error("flag event lost");
    a_flag_a_clear: assert property (
        reg_wr && reg_addr == OFS_FLAGS_A && !reg_wdata[F_SETUP]
        && !ev_a[F_SETUP] |=> !flags_a_reg[F_SETUP])
        else $error("setup flag not cleared by write 0");
    a_flag_b_clear: assert property (
        reg_wr && reg_addr == OFS_FLAGS_B && !reg_wdata[F_BRST]
        && !ev_b[F_BRST] |=> !flags_b_reg[F_BRST] && flags_b_reg[1:0] == 2'h0)
        else $error("bus reset flag not cleared");
    a_ep0_rx_clear: assert property (
        ev_a[F_EP0_RX] && !w_ctl |=> !ep_bus.ep0_rx_ready)
        else $error("ep0 receive ready not cleared");
    a_ep0_tx_clear: assert property (
        ev_a[F_EP0_TX] && !(reg_wr && reg_addr == OFS_EP0_IN)
        |=> !in_reg[0][B_READY])
        else $error("ep0 transmit ready not cleared");
    a_ep1_tx_clear: assert property (
        ev_a[F_EP1_TX] && !(reg_wr && reg_addr == OFS_EP1_IN)
        |=> !ep_bus.ready[1])
        else $error("ep1 transmit ready not cleared");
    a_ep4_rx_clear: assert property (
        ev_a[F_EP4_RX] && !w_ep4 |=> !ep4_ctrl_reg[B_READY])
        else $error("ep4 receive ready not cleared");
    a_ep4_status: assert property (
        ev_a[F_EP4_RX] |=> ep4_tgl_reg == $past(ep4_rx_data1)
        && ep4_count_reg == $past(ep4_rx_bytes))
        else $error("ep4 receive status not captured");
    a_resume_gate: assert property (
        !suspended |=> !resume_drive)
        else $error("resume driven while not suspended");
    a_pad_route: assert property (
        bus_pin_enable && !w_pin |=> pad_oe == $past(xcvr_oe))
        else $error("pads not routed to transceiver");
    a_read_addr: assert property (
        reg_rd && reg_addr == OFS_PIN_ADDR && !w_pin
        |=> reg_rdata == $past(pin_addr_reg) ##1 reg_rdata == RST_VALUE
        || $past(reg_rd))
        else $error("address register read wrong");
endmodule : usbec_regs

// ===== usbec_pkg.sv
// usbec_pkg: register map, field positions, enums of the usb endpoint block
// assumes an 8-bit register port and a single system clock
package usbec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int FUNC_ADDR_W = 7;
    localparam int CNT_W = 4;
    localparam int BULK_CNT_W = 7;
    localparam int NUM_EP = 5;
    localparam int NUM_IN = 4;
    localparam int EP_W = 4;
    localparam int EP_IDX_W = 3;
    localparam logic [7:0] OFS_PIN_ADDR = 8'hC1;
    localparam logic [7:0] OFS_FLAGS_A = 8'hC2;
    localparam logic [7:0] OFS_FLAGS_B = 8'hC3;
    localparam logic [7:0] OFS_LINK_CTRL = 8'hC4;
    localparam logic [7:0] OFS_EP0_IN = 8'hC5;
    localparam logic [7:0] OFS_EP1_IN = 8'hC6;
    localparam logic [7:0] OFS_EP2_IN = 8'hC7;
    localparam logic [7:0] OFS_EP3_IN = 8'hCE;
    localparam logic [7:0] OFS_EP4_OUT = 8'hCF;
    localparam logic [7:0] OFS_EP3_COUNT = 8'hD1;
    localparam logic [7:0] OFS_EP4_COUNT = 8'hD2;
    localparam logic [7:0] IN_OFS [NUM_IN] = '{8'hC5, 8'hC6, 8'hC7, 8'hCE};
    localparam logic [7:0] IN_WR_MASK [NUM_IN] =
        '{8'hFF, 8'hEF, 8'hEF, 8'hE0};
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] FLAGS_B_MASK = 8'hFC;
    localparam logic [7:0] LINK_CTRL_MASK = 8'hFC;
    localparam logic [7:0] EP4_CTRL_MASK = 8'hC0;
    localparam int B_PIN_EN = 7;
    localparam int B_SUSPEND = 7;
    localparam int B_RESUME = 6;
    localparam int B_EP1_CFG = 5;
    localparam int B_EP2_CFG = 4;
    localparam int B_PULLUP = 3;
    localparam int B_EP0_RXRDY = 2;
    localparam int B_READY = 7;
    localparam int B_TOGGLE = 6;
    localparam int B_STALL = 5;
    localparam int B_STALL_IN0 = 4;
    localparam int B_EP3_CFG = 4;
    localparam int B_EP4_STALL = 6;
    localparam int B_EP4_CFG = 5;
    localparam int B_EP4_TGL = 4;
    localparam int B_EP4_ERR = 3;
    localparam int F_SETUP = 7;
    localparam int F_EP0_RX = 6;
    localparam int F_EP0_TX = 5;
    localparam int F_EP1_TX = 4;
    localparam int F_EP2_TX = 3;
    localparam int F_SUSP = 2;
    localparam int F_EP3_TX = 1;
    localparam int F_EP4_RX = 0;
    localparam int F_BRST = 6;
    localparam int F_RSM = 5;
    localparam int PAD_DP = 1;
    localparam int PAD_DM = 0;
    localparam logic [EP_W-1:0] EP_CTRL = 4'h0;
    localparam logic [EP_W-1:0] EP_BULK_OUT = 4'h4;
    typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} usbec_tok_t;
    typedef enum logic [2:0] {
        RSP_NONE, RSP_ACK, RSP_NAK, RSP_STALL, RSP_DATA
    } usbec_rsp_t;
endpackage : usbec_pkg

// ===== usbec_ep_if.sv
// usbec_ep_if: endpoint state handed from register file to responder
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface usbec_ep_if;
    import usbec_pkg::*;
    logic [FUNC_ADDR_W-1:0] dev_addr;
    logic [NUM_EP-1:0] ready;
    logic [NUM_EP-1:0] stall;
    logic [NUM_EP-1:0] configured;
    logic [NUM_EP-1:0] tx_toggle;
    logic [BULK_CNT_W-1:0] tx_count [NUM_EP];
    logic ep0_rx_ready;
    logic ep0_stall_in;
    modport regs (output dev_addr, ready, stall, configured, tx_toggle,
        tx_count, ep0_rx_ready, ep0_stall_in);
    modport decide (input dev_addr, ready, stall, configured, tx_toggle,
        tx_count, ep0_rx_ready, ep0_stall_in);
endinterface : usbec_ep_if

// ===== usbec_hs_decide.sv
// usbec_hs_decide: picks the handshake for each token from endpoint state
// assumes tokens come from the serial engine on clk_sys, one cycle each
`timescale 1ns/1ps
module usbec_hs_decide (
    input wire logic clk_sys,
    input wire logic reset_n,
    usbec_ep_if.decide ep,
    input wire logic tok_valid,
    input wire usbec_pkg::usbec_tok_t tok_kind,
    input wire logic [usbec_pkg::FUNC_ADDR_W-1:0] tok_addr,
    input wire logic [usbec_pkg::EP_W-1:0] tok_ep,
    output logic rsp_valid,
    output usbec_pkg::usbec_rsp_t rsp_code,
    output logic rsp_data1,
    output logic [usbec_pkg::BULK_CNT_W-1:0] rsp_count
);
    import usbec_pkg::*;

    usbec_rsp_t code;
    logic [EP_IDX_W-1:0] idx;
    logic hit;

    assign idx = tok_ep[EP_IDX_W-1:0];
    // foreign address or unknown endpoint stays silent
    assign hit = tok_addr == ep.dev_addr && tok_ep < NUM_EP
        && ep.configured[idx];

    always_comb begin
        code = RSP_NONE;
        if (hit && tok_ep == EP_CTRL) begin
            if (tok_kind == TOK_SETUP) begin
                code = RSP_ACK;
            end else if (ep.stall[0]) begin
                code = RSP_STALL;
            end else if (tok_kind == TOK_IN) begin
                code = ep.ep0_stall_in ? RSP_STALL : ep.ready[0] ?
                    RSP_DATA : RSP_NAK;
            end else begin
                code = ep.ep0_rx_ready ? RSP_ACK : RSP_NAK;
            end
        end else if (hit && tok_ep == EP_BULK_OUT) begin
            if (tok_kind == TOK_OUT) begin
                code = ep.stall[idx] ? RSP_STALL : ep.ready[idx] ?
                    RSP_ACK : RSP_NAK;
            end
        end else if (hit && tok_kind == TOK_IN) begin
            code = ep.stall[idx] ? RSP_STALL : ep.ready[idx] ?
                RSP_DATA : RSP_NAK;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_code <= RSP_NONE;
            rsp_data1 <= 1'b0;
            rsp_count <= '0;
        end else begin
            rsp_valid <= tok_valid && code != RSP_NONE;
            rsp_code <= tok_valid ? code : RSP_NONE;
            // only valid tokens that hit a configured endpoint at this address index the endpoint arrays
            if (tok_valid && hit) begin
                rsp_data1 <= ep.tx_toggle[idx];
                rsp_count <= ep.tx_count[idx];
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_in_stall_ep1: assert property (
        tok_valid && tok_kind == TOK_IN && hit && idx == 3'h1
        && ep.stall[1] |=> rsp_valid && rsp_code == RSP_STALL)
        else $error("stalled endpoint 1 did not stall IN");
    a_out_nak_idle: assert property (
        tok_valid && tok_kind == TOK_OUT && hit && tok_ep == EP_BULK_OUT
        && !ep.stall[4] && !ep.ready[4] |=> rsp_code == RSP_NAK)
        else $error("idle bulk OUT endpoint did not NAK");
endmodule : usbec_hs_decide

// ===== usbec_host_model.sv
// usbec_host_model: token and engine event source facing the block
// assumes one caller at a time, all changes just after clk_sys rises
`timescale 1ns/1ps
module usbec_host_model (
    input wire logic clk_sys,
    output logic tok_valid,
    output usbec_pkg::usbec_tok_t tok_kind,
    output logic [usbec_pkg::FUNC_ADDR_W-1:0] tok_addr,
    output logic [usbec_pkg::EP_W-1:0] tok_ep,
    output logic [7:0] ev_a,
    output logic [7:0] ev_b
);
    import usbec_pkg::*;
    initial begin
        tok_valid = 1'b0;
        tok_kind = TOK_OUT;
        tok_addr = 7'h7F;
        tok_ep = 4'hF;
        ev_a = 8'h00;
        ev_b = 8'h00;
    end
    // idle address shows the inverse, so a stale match cannot hide
    task automatic send(usbec_tok_t k, logic [6:0] a, logic [3:0] e);
        @(posedge clk_sys);
        tok_valid <= 1'b1;
        tok_kind <= k;
        tok_addr <= a;
        tok_ep <= e;
        @(posedge clk_sys);
        tok_valid <= 1'b0;
        tok_addr <= ~a;
    endtask : send
    task automatic pulse(logic [7:0] a, logic [7:0] b);
        @(posedge clk_sys);
        ev_a <= a;
        ev_b <= b;
        @(posedge clk_sys);
        ev_a <= 8'h00;
        ev_b <= 8'h00;
    endtask : pulse
endmodule : usbec_host_model

// ===== usb_endpoint_control_regs_bench.sv
// usb_endpoint_control_regs_bench: register and token sequences
// assumes pads loop back to their own inputs
`timescale 1ns/1ps
module usb_endpoint_control_regs_bench;
    import usbec_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ev_a, ev_b;
    logic reg_wr = 1'b0, reg_rd = 1'b0, tok_valid, rsp_valid, rsp_data1;
    logic bus_pin_enable, suspend_req, resume_drive, pullup_en;
    logic ep4_rx_data1 = 1'b0, ep4_rx_error = 1'b0;
    logic [6:0] ep4_rx_bytes = 7'h00, tok_addr, rsp_count, device_bus_address;
    logic [3:0] tok_ep;
    logic [1:0] xcvr_o = 2'h2, pad_i, pad_o, pad_oe, xcvr_i, xcvr_oe, gpio_i;
    logic [1:0] gpio_o, gpio_oe;
    usbec_tok_t tok_kind;
    usbec_rsp_t rsp_code;
    int n_mismatch = 0, checked = 0, cyc = 0;
    assign pad_i = pad_o;
    assign xcvr_oe = xcvr_o;
    assign gpio_o = ~xcvr_o;
    assign gpio_oe = ~xcvr_o;
    always #25 clk_sys = ~clk_sys;
    usbec_regs dut (.*);
    usbec_host_model host (.*);
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask : rd
    task automatic tk(usbec_tok_t k, logic [3:0] e, usbec_rsp_t r);
        host.send(k, 7'h05, e);
        #1 chk("rsp_code", 8'(rsp_code), 8'(r));
        chk("rsp_valid", {7'h0, rsp_valid}, {7'h0, r != RSP_NONE});
    endtask : tk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // whole run needs about 130 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'hC1 + 8'(i), 8'h00);
        rd(OFS_EP3_IN, 8'h00);
        rd(8'hC0, 8'h00);
        chk("pads", {2'h0, pad_oe, gpio_i, xcvr_i}, 8'h14);
        $display("test reset done");
        wr(OFS_PIN_ADDR, 8'h85);
        rd(OFS_PIN_ADDR, 8'h85);
        repeat (3) @(posedge clk_sys);
        #1 chk("addr", {1'b0, device_bus_address}, 8'h05);
        chk("pad_o", {6'h0, pad_o}, {6'h0, xcvr_o});
        chk("xcvr_i", {6'h0, xcvr_i}, {6'h0, xcvr_o});
        chk("pads", {2'h0, pad_oe, gpio_i, xcvr_i}, 8'h22);
        wr(OFS_LINK_CTRL, 8'hC8);
        repeat (2) @(posedge clk_sys);
        #1 chk("link", {5'h0, suspend_req, resume_drive, pullup_en},
            8'h07);
        host.pulse(8'hFF, 8'hFF);
        rd(OFS_FLAGS_A, 8'hFF);
        rd(OFS_FLAGS_B, 8'hFC);
        wr(OFS_FLAGS_A, 8'h0F);
        rd(OFS_FLAGS_A, 8'h0F);
        wr(OFS_FLAGS_B, 8'hBC);
        rd(OFS_FLAGS_B, 8'hBC);
        $display("test flags done");
        wr(OFS_EP0_IN, 8'h83);
        tk(TOK_IN, 4'h0, RSP_DATA);
        chk("rsp_count", {1'b0, rsp_count}, 8'h03);
        host.pulse(8'h20, 8'h00);
        rd(OFS_EP0_IN, 8'h03);
        tk(TOK_IN, 4'h0, RSP_NAK);
        wr(OFS_EP0_IN, 8'h10);
        tk(TOK_IN, 4'h0, RSP_STALL);
        tk(TOK_OUT, 4'h0, RSP_NAK);
        wr(OFS_LINK_CTRL, 8'hCC);
        tk(TOK_OUT, 4'h0, RSP_ACK);
        host.pulse(8'h40, 8'h00);
        rd(OFS_LINK_CTRL, 8'hC8);
        wr(OFS_EP0_IN, 8'h20);
        tk(TOK_OUT, 4'h0, RSP_STALL);
        $display("test ep0 done");
        tk(TOK_IN, 4'h1, RSP_NONE);
        wr(OFS_LINK_CTRL, 8'hF8);
        wr(OFS_EP1_IN, 8'hC5);
        tk(TOK_IN, 4'h1, RSP_DATA);
        chk("rsp_data1", {7'h0, rsp_data1}, 8'h01);
        chk("rsp_count", {1'b0, rsp_count}, 8'h05);
        host.pulse(8'h10, 8'h00);
        tk(TOK_IN, 4'h1, RSP_NAK);
        wr(OFS_EP1_IN, 8'h20);
        tk(TOK_IN, 4'h1, RSP_STALL);
        $display("test ep1 done");
        wr(OFS_EP3_IN, 8'hD0);
        wr(OFS_EP3_COUNT, 8'h40);
        tk(TOK_IN, 4'h3, RSP_DATA);
        chk("rsp_count", {1'b0, rsp_count}, 8'h40);
        host.pulse(8'h02, 8'h00);
        tk(TOK_IN, 4'h3, RSP_NAK);
        rd(OFS_EP3_IN, 8'h50);
        wr(OFS_EP3_IN, 8'h20);
        tk(TOK_IN, 4'h3, RSP_STALL);
        wr(OFS_EP4_OUT, 8'hA0);
        tk(TOK_OUT, 4'h4, RSP_ACK);
        @(posedge clk_sys);
        ep4_rx_data1 <= 1'b1;
        ep4_rx_bytes <= 7'h2A;
        host.pulse(8'h01, 8'h00);
        rd(OFS_EP4_OUT, 8'h30);
        rd(OFS_EP4_COUNT, 8'h2A);
        tk(TOK_OUT, 4'h4, RSP_NAK);
        wr(OFS_EP4_OUT, 8'h40);
        tk(TOK_OUT, 4'h4, RSP_STALL);
        $display("test bulk done");
        end_sim();
    end
endmodule : usb_endpoint_control_regs_bench
